//--- mdah_regs.vh
// offsets, fields, reset values and timing counts of the fault handling block
`ifndef MDAH_REGS_VH
`define MDAH_REGS_VH
// register byte offsets
`define MDAH_OFF_CTRL      8'h00
`define MDAH_OFF_STATUS    8'h04
`define MDAH_OFF_IRQSTAT   8'h08
`define MDAH_OFF_IRQMASK   8'h0C
`define MDAH_OFF_CMD       8'h10
`define MDAH_OFF_RAISE     8'h14
// ctrl fields
`define MDAH_CTRL_CODEEN   0
`define MDAH_CTRL_RESET    32'h0000_0000
// cmd fields
`define MDAH_CMD_CLEAR     0
// fault source indices within the 8-bit source vector
`define MDAH_SRC_OVERHEAT  0
`define MDAH_SRC_OVERLOAD  1
`define MDAH_SRC_OVERSPEED 2
`define MDAH_SRC_PULSEERR  3
`define MDAH_SRC_OVERVOLT  4
`define MDAH_SRC_REGENHOT  5
`define MDAH_SRC_ABNDATA   6
`define MDAH_SRC_SPARE     7
// sources that only a power cycle clears
`define MDAH_NORESET_MASK  8'h20
// alarm numbers reported in status
`define MDAH_CODE_OVERHEAT  8'h21
`define MDAH_CODE_OVERLOAD  8'h30
`define MDAH_CODE_OVERSPEED 8'h31
`define MDAH_CODE_PULSEERR  8'h34
`define MDAH_CODE_OVERVOLT  8'h22
`define MDAH_CODE_REGENHOT  8'h51
`define MDAH_CODE_ABNDATA   8'h70
// speed and pulse limits
`define MDAH_SPEED_LIMIT    16'h1194
`define MDAH_PULSE_LIMIT    20'h7_A120
// blink timing, ms and derived cycles at 250 MHz
`define MDAH_CLK_MHZ        250
`define MDAH_BLINK_MS       200
`define MDAH_GAP_MS         1200
// irq bit positions
`define MDAH_IRQ_ALARM      0
`define MDAH_IRQ_WARN       1
`define MDAH_IRQ_CLEARED    2
`endif

//--- mdah_blinker.v
// fault indicator blinker: groups of n blinks separated by a long gap
`timescale 1ns/1ps
`default_nettype none
`include "mdah_regs.vh"
module mdah_blinker #(
  parameter [31:0] HALF_CYCLES = `MDAH_BLINK_MS * 1000 * `MDAH_CLK_MHZ,
  parameter [31:0] GAP_CYCLES  = `MDAH_GAP_MS * 1000 * `MDAH_CLK_MHZ
) (
  input  wire       clk_sys,
  input  wire       rst_n,
  input  wire       enable,
  input  wire [3:0] blinkCount,
  output reg        ledOut
);
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_ON   = 3'b010;
  localparam [2:0] ST_OFF  = 3'b100;
  reg [2:0]  state_reg;
  reg [31:0] timer_reg;
  reg [3:0]  done_reg;
  // group sequencer: on, off, repeat n times, then a long dark gap
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      timer_reg <= 32'h0000_0000;
      done_reg  <= 4'h0;
      ledOut    <= 1'b0;
    end else if (!enable || blinkCount == 4'h0) begin
      state_reg <= ST_IDLE;
      timer_reg <= 32'h0000_0000;
      done_reg  <= 4'h0;
      ledOut    <= 1'b0;
    end else if (timer_reg != 32'h0000_0000) begin
      timer_reg <= timer_reg - 32'h0000_0001;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          state_reg <= ST_ON;
          ledOut    <= 1'b1;
          timer_reg <= HALF_CYCLES - 32'h0000_0001;
        end
        ST_ON: begin
          state_reg <= ST_OFF;
          ledOut    <= 1'b0;
          done_reg  <= done_reg + 4'h1;
          // last blink of the group gets the long gap
          timer_reg <= (done_reg + 4'h1 >= blinkCount) ? GAP_CYCLES - 32'h0000_0001
                                                       : HALF_CYCLES - 32'h0000_0001;
        end
        ST_OFF: begin
          if (done_reg >= blinkCount)
            done_reg <= 4'h0;
          state_reg <= ST_ON;
          ledOut    <= 1'b1;
          timer_reg <= HALF_CYCLES - 32'h0000_0001;
        end
        default: begin
          state_reg <= ST_IDLE;
          ledOut    <= 1'b0;
        end
      endcase
    end
  end
endmodule // mdah_blinker
`default_nettype wire

//--- mdah_fault_ctrl.v
// motor driver fault handling: latch, outputs, code mux, blink, clear, ahb-lite regs
// Notes on behaviour
// RULE1 - any alarm drops the fault output and stops the motor
// RULE2 - abnormal-data alarm keeps current flowing and motor running, still signalled
// RULE3 - code output mode puts code bits 0,1,2 on ready, limit, timing outputs
// RULE4 - code output setting: 0 disabled, 1 enabled, resets to 0
// RULE5 - while alarmed, indicator blinks in groups; blink count names the alarm; here overheat, overload, overspeed and pulse error all give 2 blinks
// RULE6 - overvoltage alarm blinks three times per group
// RULE7 - resettable alarm clears on the falling edge of the clear input
// RULE8 - software alarm-reset command also clears resettable alarms
// RULE9 - power-cycle-only alarms ignore clear input and software command
// RULE10 - warnings are raised before the alarm threshold, motor keeps running
// RULE11 - overspeed above 4500 r/min gives resettable alarm 31, no excitation
// RULE12 - command pulse rate above limit gives resettable alarm 34, no excitation
// RULE13 - alarm stays latched with outputs stable until a valid clear
`timescale 1ns/1ps
`default_nettype none
`include "mdah_regs.vh"
module mdah_fault_ctrl #(
  // blink timing in clock cycles; a bench may shrink them to watch whole groups
  parameter [31:0] BLINK_HALF = `MDAH_BLINK_MS * 1000 * `MDAH_CLK_MHZ,
  parameter [31:0] BLINK_GAP  = `MDAH_GAP_MS * 1000 * `MDAH_CLK_MHZ
) (
  input  wire        clk_sys,
  input  wire        rst_n,
  // ahb-lite slave
  input  wire        hsel,
  input  wire [7:0]  haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // drive-side inputs
  input  wire        faultClearInput,
  input  wire [15:0] shaftSpeed,
  input  wire [19:0] pulseRate,
  input  wire [7:0]  faultSources,
  input  wire [7:0]  warnSources,
  input  wire        readyStatus,
  input  wire        limitStatus,
  input  wire        timingStatus,
  // drive-side outputs
  output reg         faultOutput,
  output reg         excitationEnable,
  output reg         motorRunEnable,
  output reg         readyOutput,
  output reg         limitReachedOutput,
  output reg         excitationTimingOutput,
  output reg         warningOutput,
  output reg         faultBlinkIndicator,
  output reg         irq
);
  reg        codeEn_reg;
  reg [7:0]  latch_reg;
  reg [7:0]  latch_next;
  reg [2:0]  irqStat_reg;
  reg [2:0]  irqMask_reg;
  reg        clrDly_reg;
  reg        cmdClr_reg;
  reg [7:0]  swRaise_reg;
  reg        apValid_reg;
  reg        apWrite_reg;
  reg [7:0]  apAddr_reg;
  reg [7:0]  alarmNum;
  reg [2:0]  codeBits;
  reg [3:0]  blinks;
  wire       blinkLed;
  wire [7:0] rawFault;
  wire       clearEdge;
  wire [7:0] clearMask;
  wire       anyStop;
  wire       wrStrobe;
  integer    i;

  // priority pick of the reported alarm, lowest index wins
  // one pick feeds the number, the code bits and the blink count
  function [7:0] pick_src;
    input [7:0] v;
    integer k;
    begin
      pick_src = 8'h00;
      for (k = 7; k >= 0; k = k - 1)
        if (v[k])
          pick_src = 8'h01 << k;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // fault detection
  assign rawFault[`MDAH_SRC_OVERSPEED] = faultSources[`MDAH_SRC_OVERSPEED] |
                                         (shaftSpeed > `MDAH_SPEED_LIMIT); // [RULE11]
  assign rawFault[`MDAH_SRC_PULSEERR]  = faultSources[`MDAH_SRC_PULSEERR] |
                                         (pulseRate > `MDAH_PULSE_LIMIT);  // [RULE12]
  // overspeed and pulse error bits are built above; overheat and overload pass straight, bits 7:4 also take swRaise_reg
  assign rawFault[`MDAH_SRC_OVERHEAT] = faultSources[`MDAH_SRC_OVERHEAT];
  assign rawFault[`MDAH_SRC_OVERLOAD] = faultSources[`MDAH_SRC_OVERLOAD];
  assign rawFault[7:4] = faultSources[7:4] | swRaise_reg[7:4];

  // clear on off-edge of the clear input or software command
  // the delay flop resets to the off level, so no false edge follows reset
  assign clearEdge = clrDly_reg & ~faultClearInput; // [RULE7]
  // power-cycle-only alarms are masked out of any clear
  assign clearMask = (clearEdge | cmdClr_reg) ? ~`MDAH_NORESET_MASK : 8'h00; // [RULE8] [RULE9]

  // latched alarms: a new fault wins over a clear in the same cycle
  // a source still high at the clear simply latches again
  always @* begin
    latch_next = (latch_reg & ~clearMask) | rawFault; // [RULE13]
  end

  // alarm latch and the delay flop of the clear input
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      latch_reg  <= 8'h00;
      clrDly_reg <= 1'b0;
    end else begin
      latch_reg  <= latch_next;
      clrDly_reg <= faultClearInput;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // alarm number, code bits and blink count of the reported alarm
  // the spare source has no fixed pattern, so its number and count are local picks
  always @* begin
    alarmNum = 8'h00;
    codeBits = 3'b000;
    blinks   = 4'h0;
    case (pick_src(latch_reg))
      8'h01: begin
        alarmNum = `MDAH_CODE_OVERHEAT;
        codeBits = 3'b010;
        blinks   = 4'h2;
      end
      8'h02: begin
        alarmNum = `MDAH_CODE_OVERLOAD;
        codeBits = 3'b010;
        blinks   = 4'h2;
      end
      8'h04: begin
        alarmNum = `MDAH_CODE_OVERSPEED;
        codeBits = 3'b010;
        blinks   = 4'h2;
      end
      8'h08: begin
        alarmNum = `MDAH_CODE_PULSEERR;
        codeBits = 3'b010;
        blinks   = 4'h2;
      end
      8'h10: begin
        alarmNum = `MDAH_CODE_OVERVOLT;
        codeBits = 3'b011;
        blinks   = 4'h3; // [RULE6]
      end
      8'h20: begin
        alarmNum = `MDAH_CODE_REGENHOT;
        codeBits = 3'b100;
        blinks   = 4'h4;
      end
      8'h40: begin
        alarmNum = `MDAH_CODE_ABNDATA;
        codeBits = 3'b111;
        blinks   = 4'h7;
      end
      8'h80: begin
        alarmNum = 8'hFF;
        codeBits = 3'b110;
        blinks   = 4'h9;
      end
      default: begin
        alarmNum = 8'h00;
        codeBits = 3'b000;
        blinks   = 4'h0;
      end
    endcase
  end

  // abnormal-data alarm alone does not cut the motor current
  assign anyStop = |(latch_reg & ~(8'h01 << `MDAH_SRC_ABNDATA));

  ////////////////////////////////////////////////////////////////////
  // blinker, grouped by the reported alarm
  mdah_blinker #(
    .HALF_CYCLES (BLINK_HALF),
    .GAP_CYCLES  (BLINK_GAP)
  ) u_blink (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .enable     (|latch_reg),
    .blinkCount (blinks),
    .ledOut     (blinkLed)
  ); // [RULE5]

  ////////////////////////////////////////////////////////////////////
  // registered drive outputs
  // status outputs pass through a flop as well, so a mode switch cannot glitch
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      faultOutput            <= 1'b0;
      excitationEnable       <= 1'b0;
      motorRunEnable         <= 1'b0;
      readyOutput            <= 1'b0;
      limitReachedOutput     <= 1'b0;
      excitationTimingOutput <= 1'b0;
      warningOutput          <= 1'b0;
      faultBlinkIndicator    <= 1'b0;
    end else begin
      // fault output is on while healthy, off on any alarm
      faultOutput            <= ~|latch_reg;      // [RULE1]
      excitationEnable       <= ~anyStop;         // [RULE1] [RULE2] [RULE11] [RULE12]
      motorRunEnable         <= ~anyStop;         // [RULE2]
      warningOutput          <= |warnSources;     // [RULE10]
      faultBlinkIndicator    <= blinkLed;
      if (codeEn_reg) begin
        readyOutput            <= codeBits[0];    // [RULE3]
        limitReachedOutput     <= codeBits[1];    // [RULE3]
        excitationTimingOutput <= codeBits[2];    // [RULE3]
      end else begin
        readyOutput            <= readyStatus & ~anyStop;
        limitReachedOutput     <= limitStatus;
        excitationTimingOutput <= timingStatus;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // ahb-lite slave: zero wait, always okay
  // hreadyout stays high, so a read is decoded in its address phase
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      apValid_reg <= 1'b0;
      apWrite_reg <= 1'b0;
      apAddr_reg  <= 8'h00;
    end else if (hready) begin
      apValid_reg <= hsel & htrans[1];
      apWrite_reg <= hwrite;
      apAddr_reg  <= haddr;
    end
  end

  // write strobe of the data phase, shared by the sticky clear and the decode
  assign wrStrobe = apValid_reg & apWrite_reg;

  // writes, status stickies and command pulse
  // cmd and raise are one-cycle strobes and read back as zero
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      codeEn_reg  <= 1'b0; // [RULE4]
      irqStat_reg <= 3'b000;
      irqMask_reg <= 3'b000;
      cmdClr_reg  <= 1'b0;
      swRaise_reg <= 8'h00;
    end else begin
      cmdClr_reg  <= 1'b0;
      swRaise_reg <= 8'h00;
      // set beats write-one-to-clear in the same cycle
      for (i = 0; i < 3; i = i + 1) begin
        if (wrStrobe && apAddr_reg == `MDAH_OFF_IRQSTAT && hwdata[i])
          irqStat_reg[i] <= 1'b0;
      end
      if (|(latch_next & ~latch_reg))
        irqStat_reg[`MDAH_IRQ_ALARM] <= 1'b1;
      if (|warnSources && !warningOutput)
        irqStat_reg[`MDAH_IRQ_WARN] <= 1'b1;
      if (|(latch_reg & ~latch_next))
        irqStat_reg[`MDAH_IRQ_CLEARED] <= 1'b1;
      if (wrStrobe) begin
        case (apAddr_reg)
          `MDAH_OFF_CTRL:    codeEn_reg  <= hwdata[`MDAH_CTRL_CODEEN]; // [RULE4]
          `MDAH_OFF_IRQMASK: irqMask_reg <= hwdata[2:0];
          `MDAH_OFF_CMD:     cmdClr_reg  <= hwdata[`MDAH_CMD_CLEAR];   // [RULE8]
          `MDAH_OFF_RAISE:   swRaise_reg <= hwdata[7:0];
          default:           cmdClr_reg  <= 1'b0;
        endcase
      end
    end
  end

  // read data and bus outputs
  // irq is registered, so it trails the sticky bits by one cycle
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      irq       <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      irq       <= |(irqStat_reg & irqMask_reg);
      if (hready && hsel && htrans[1] && !hwrite) begin
        case (haddr)
          `MDAH_OFF_CTRL:    hrdata <= {{31{1'b0}}, codeEn_reg};
          `MDAH_OFF_STATUS:  hrdata <= {8'h00, alarmNum, latch_reg, 6'h00, warningOutput,
                                        faultOutput};
          `MDAH_OFF_IRQSTAT: hrdata <= {{29{1'b0}}, irqStat_reg};
          `MDAH_OFF_IRQMASK: hrdata <= {{29{1'b0}}, irqMask_reg};
          default:           hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule // mdah_fault_ctrl
`default_nettype wire

//--- mdah_fault_ctrl_assertions.sv
// port-level assertions for the fault handling block
`timescale 1ns/1ps
`default_nettype none
module mdah_fault_ctrl_assertions (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        hsel,
  input wire logic        faultClearInput,
  input wire logic [15:0] shaftSpeed,
  input wire logic [19:0] pulseRate,
  input wire logic [7:0]  faultSources,
  input wire logic [7:0]  warnSources,
  input wire logic        faultOutput,
  input wire logic        excitationEnable,
  input wire logic        motorRunEnable,
  input wire logic        warningOutput,
  input wire logic        faultBlinkIndicator
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  //////////////////////////////////////////////////////////////////////////////
  // trips: two stages of latency, margin one on the drop and two on speed and pulse; the speed and pulse compares add no stage
  a_fault_drop: assert property ($rose(faultSources[4]) |-> ##3
    (!faultOutput && !excitationEnable && !motorRunEnable)) else $error("alarm left motor on");
  a_speed_trip: assert property ((shaftSpeed > 16'h1194)[*4] |=> !faultOutput)
    else $error("overspeed not latched");
  a_pulse_trip: assert property ((pulseRate > 20'h7_A120)[*4] |=> !faultOutput)
    else $error("pulse error not latched");
  // six quiet cycles cover any clear still in flight
  a_latch_hold: assert property ((!faultOutput && !faultClearInput && !hsel)[*6]
    |=> !faultOutput) else $error("alarm dropped without clear");
  a_clear_held: assert property ((!faultOutput && faultClearInput && !hsel)[*6]
    |=> !faultOutput) else $error("alarm cleared on the on level");
  a_noreset_hold: assert property ($rose(faultSources[5]) |-> ##3
    (!faultOutput)[*6]) else $error("power cycle alarm cleared");
  a_warn_follow: assert property (warningOutput == |$past(warnSources))
    else $error("warning output wrong");
  a_blink_idle: assert property (faultOutput[*4] |-> !faultBlinkIndicator)
    else $error("indicator active while healthy");
endmodule // mdah_fault_ctrl_assertions
bind mdah_fault_ctrl mdah_fault_ctrl_assertions i_chk (.clk_sys(clk_sys), .rst_n(rst_n),
  .hsel(hsel), .faultClearInput(faultClearInput), .shaftSpeed(shaftSpeed),
  .pulseRate(pulseRate), .faultSources(faultSources), .warnSources(warnSources),
  .faultOutput(faultOutput), .excitationEnable(excitationEnable),
  .motorRunEnable(motorRunEnable), .warningOutput(warningOutput),
  .faultBlinkIndicator(faultBlinkIndicator));
`default_nettype wire

//--- mdah_host_model.sv
// host controller model pulsing the fault clear line
`timescale 1ns/1ps
`default_nettype none
module mdah_host_model #(
  parameter int ON_CYCLES = 8
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic clrReq,
  output var  logic faultClearInput
);
  int onCnt_reg;
  // on while asked, then a fixed hold; a long request answers slowly
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      onCnt_reg <= 0;
      faultClearInput <= 1'b0;
    end else begin
      onCnt_reg <= clrReq ? ON_CYCLES : (onCnt_reg != 0 ? onCnt_reg - 1 : 0);
      faultClearInput <= clrReq || onCnt_reg > 1;
    end
  end
endmodule // mdah_host_model
`default_nettype wire

//--- tb.sv
// self-checking bench for the fault handling block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk_sys = 0, rst_n = 0, hsel = 0, hwrite = 0, clrReq = 0;
  logic [1:0]  htrans = 0;
  logic [2:0]  stat = 0, code;
  logic [7:0]  haddr = 0, faultSources = 0, warnSources = 0;
  logic [15:0] shaftSpeed = 0;
  logic [19:0] pulseRate = 0;
  logic [31:0] hwdata = 0, q;
  wire  [31:0] hrdata;
  wire         hreadyout, hresp, fci, fo, exc, run, rdyO, limO, timO, warnO, led, irq;
  int          n_mismatch = 0, total_checks = 0, cycles = 0, nb = 0;
  //////////////////////////////////////////////////////////////////////////////
  // short blink timing: on 4, off 4, gap 16 cycles, so a whole group fits a test
  mdah_fault_ctrl #(.BLINK_HALF(32'h0000_0004), .BLINK_GAP(32'h0000_0010)) i_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .faultClearInput(fci),
    .shaftSpeed(shaftSpeed), .pulseRate(pulseRate), .faultSources(faultSources),
    .warnSources(warnSources), .readyStatus(stat[2]), .limitStatus(stat[1]),
    .timingStatus(stat[0]), .faultOutput(fo), .excitationEnable(exc), .motorRunEnable(run),
    .readyOutput(rdyO), .limitReachedOutput(limO), .excitationTimingOutput(timO),
    .warningOutput(warnO), .faultBlinkIndicator(led), .irq(irq));
  mdah_host_model i_host (.clk_sys(clk_sys), .rst_n(rst_n), .clrReq(clrReq),
    .faultClearInput(fci));
  //////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial forever #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // indicator rises over w cycles; w is one group period, so the count is exact
  task automatic blink_count(input int w, output int n);
    logic prev;
    prev = led;
    n = 0;
    repeat (w) begin
      @(posedge clk_sys);
      if (led && !prev) n++;
      prev = led;
    end
  endtask
  // one single transfer; address held until ready, then data phase
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic clr();
    clrReq <= 1'b1;
    @(posedge clk_sys);
    clrReq <= 1'b0;
    cyc(14);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    cyc(2);
    bus(0, 8'h00, 0);
    chk(q, 32'h0000_0000);
    stat <= 3'b101;
    cyc(3);
    chk(32'({rdyO, limO, timO, fo, exc, run}), 32'h0000_002F);
    bus(1, 8'h0C, 32'h0000_0007);
    faultSources <= 8'h10;
    cyc(4);
    chk(32'({fo, exc, run, irq}), 32'h0000_0001);
    faultSources <= 8'h00;
    cyc(20);
    chk(32'(fo), 32'h0000_0000);
    // overvolt group: three blinks of 8 cycles less one off, then the gap
    blink_count(36, nb);
    chk(32'(nb), 32'h0000_0003);
    bus(0, 8'h04, 0);
    chk(32'(q[23:16]), 32'h0000_0022);
    // code mode: outputs must stop following the status inputs
    bus(1, 8'h00, 32'h0000_0001);
    cyc(3);
    code = {rdyO, limO, timO};
    stat <= 3'b010;
    cyc(3);
    chk(32'({rdyO, limO, timO}), 32'(code));
    clr();
    faultSources <= 8'h01;
    cyc(4);
    faultSources <= 8'h00;
    // overheat code: bit 1 only, on the limit output
    chk(32'({timO, limO, rdyO}), 32'h0000_0002);
    blink_count(28, nb);
    chk(32'(nb), 32'h0000_0002);
    bus(1, 8'h00, 32'h0000_0000);
    clr();
    chk(32'({fo, exc, run}), 32'h0000_0007);
    bus(1, 8'h08, 32'h0000_0007);
    cyc(2);
    chk(32'(irq), 32'h0000_0000);
    // speed boundary, then one above
    shaftSpeed <= 16'h1194;
    cyc(6);
    chk(32'(fo), 32'h0000_0001);
    shaftSpeed <= 16'h1195;
    cyc(6);
    shaftSpeed <= 16'h0000;
    bus(0, 8'h04, 0);
    chk(32'({fo, exc, q[23:16]}), 32'h0000_0031);
    bus(1, 8'h10, 32'h0000_0001);
    cyc(6);
    chk(32'(fo), 32'h0000_0001);
    pulseRate <= 20'h7_A121;
    cyc(6);
    pulseRate <= 20'h0_0000;
    bus(0, 8'h04, 0);
    chk(32'({fo, exc, q[23:16]}), 32'h0000_0034);
    clr();
    faultSources <= 8'h40;
    cyc(5);
    chk(32'({fo, exc, run}), 32'h0000_0003);
    faultSources <= 8'h00;
    clr();
    warnSources <= 8'h01;
    cyc(4);
    chk(32'({warnO, exc, fo}), 32'h0000_0007);
    warnSources <= 8'h00;
    bus(0, 8'h20, 0);
    chk(q, 32'h0000_0000);
    // power-cycle-only alarm survives both clear paths
    faultSources <= 8'h20;
    cyc(4);
    faultSources <= 8'h00;
    clr();
    bus(1, 8'h10, 32'h0000_0001);
    cyc(6);
    chk(32'(fo), 32'h0000_0000);
    rst_n <= 1'b0;
    cyc(2);
    rst_n <= 1'b1;
    cyc(3);
    chk(32'(fo), 32'h0000_0001);
    finish_test();
  end
endmodule // tb
`default_nettype wire
